// ### rtl/ctb_capture_timer.sv
// Capture timer control: APB registers, clock source, count modes and waveform pin.
// Assumes an APB master on core_clk and a synchronous event input and companion timer.
// Functional notes
// R1 - Enable bit starts the timer; clear stops counting.
// R2 - Clock source: undivided, halved, or companion clock.
// R3 - Standby run keeps counting; ignored with companion clock.
// R4 - Sync bit restarts counter on companion restart.
// R5 - Single-shot synced: output high when counter starts.
// R6 - Single-shot async: output high when event arrives.
// R7 - Start level bit sets initial pin level.
// R8 - Start level ignored in eight-bit and single-shot.
// R9 - Pin enable lets waveform override port output.
// R10 - Software sets the pin direction to output.
// R11 - Count mode field selects one of eight modes.
// R12 - Filter bit enables event noise cancellation.
// R13 - Accept bit lets events act; otherwise ignored.
// R14 - Periodic and eight-bit modes ignore event edges.
// R15 - Timeout mode: selected edge starts, other stops.
// R16 - Snapshot mode: selected edge captures and flags.
// R17 - Period mode: capture, clear and restart, flag.
// R18 - Width mode: one edge restarts, other captures.
// R19 - Period-and-width: restart, capture, then stop and flag.
// R20 - Single-shot: rising starts, or either edge.
// R21 - Filter needs four equal samples, four cycles delay.
// R22 - Events last at least one clock cycle.
// R23 - Flag clears on write one or capture read.
// R24 - Unused control bits read zero; fields reset zero.
//
// Register access over APB was left to the implementer.
module ctb_capture_timer
  import ctb_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic eventIn,
  input wire logic companionTick,
  input wire logic companionRestart,
  input wire logic standbySleep,
  output logic waveformOut,
  output logic waveformOe
);
  // True for every address that holds a register.
  function automatic logic isMapped(input logic [7:0] a);
    return a == ADR_MAIN || a == ADR_MODE || a == ADR_EVT || a == ADR_FLAGS ||
           a == ADR_STATUS || a == ADR_CNT || a == ADR_CCMP;
  endfunction : isMapped

  logic [7:0] ctrlMain; // First control register.
  logic [7:0] ctrlMode; // Second control register.
  logic [7:0] evtCtrl; // Event control register.
  logic [15:0] cnt; // Counter.
  logic [15:0] ccmp; // Capture, compare and top value.
  logic capFlag; // Capture flag.
  logic runFlag; // Run state for the modes that start on events and stop on events or at top.
  logic waveLevel; // Registered waveform level.
  logic halfTick; // Divide-by-two toggle.
  logic primed; // Read data is loaded and the access may complete.
  ctb_phase_t phase; // Period-and-width measurement phase.
  ctb_evt_if evt (); // Conditioned event from the filter.

  // Field decode.
  logic enable;
  logic [1:0] clock_source_select;
  logic companionSync;
  logic standbyRun;
  logic [2:0] mode;
  logic pinEn;
  logic startLevel;
  logic asyncOut;
  logic accept;
  logic edgeSel;
  logic filterOn;
  assign enable = ctrlMain[BIT_ENABLE];
  assign clock_source_select = ctrlMain[LSB_CLOCK_SOURCE_SELECT +: 2];
  assign companionSync = ctrlMain[BIT_SYNC];
  assign standbyRun = ctrlMain[BIT_STDBY];
  assign mode = ctrlMode[LSB_MODE +: 3];
  assign pinEn = ctrlMode[BIT_PINEN];
  assign startLevel = ctrlMode[BIT_INIT];
  assign asyncOut = ctrlMode[BIT_ASYNC];
  assign accept = evtCtrl[BIT_ACCEPT];
  assign edgeSel = evtCtrl[BIT_EDGE];
  assign filterOn = evtCtrl[BIT_FILTER];

  // Bus strobes.
  logic access;
  logic wrEn;
  logic rdCcmp;
  logic cntWrite;
  logic ccmpWrite;
  assign pready = ce & psel & penable & primed;
  assign access = psel & penable & pready;
  assign pslverr = pready & ~isMapped(paddr);
  assign wrEn = access & pwrite & isMapped(paddr);
  assign rdCcmp = access & ~pwrite & (paddr == ADR_CCMP);
  assign cntWrite = wrEn & (paddr == ADR_CNT);
  assign ccmpWrite = wrEn & (paddr == ADR_CCMP);

  // Event conditioning with the optional noise filter.
  ctb_event_filter u_filter (
    .core_clk(core_clk),
    .rst(rst),
    .ce(ce),
    .eventIn(eventIn),
    .filterOn(filterOn), // R12
    .evt(evt)
  );

  // Timing and event terms.
  logic srcTick;
  logic halted;
  logic active;
  logic countTick;
  logic eventsOn;
  logic selEdge;
  logic oppEdge;
  logic startEdge;
  logic freeMode;
  logic running;
  logic hitTop;
  logic syncRestart;
  logic restartNow;
  logic capNow;
  logic flagSet;
  logic singleMode;

  // The source tick picks the counting rate.
  always_comb begin
    unique case (clock_source_select)
      SRC_UNDIV: srcTick = 1'b1; // R2
      SRC_HALVED: srcTick = halfTick; // R2
      SRC_BORROWED: srcTick = companionTick; // R2
      default: srcTick = 1'b0;
    endcase
  end

  assign halted = standbySleep & ~standbyRun & (clock_source_select != SRC_BORROWED); // R3
  assign active = enable & ~halted; // R1
  assign countTick = active & srcTick;
  assign eventsOn = active & accept; // R13
  assign selEdge = eventsOn & (edgeSel ? evt.fall : evt.rise);
  assign oppEdge = eventsOn & (edgeSel ? evt.rise : evt.fall);
  assign startEdge = eventsOn & (evt.rise | (edgeSel & evt.fall)); // R20
  assign singleMode = (mode == MODE_SINGLE);
  assign freeMode = !(mode == MODE_TIMEOUT || mode == MODE_PERWIDTH || singleMode);
  assign running = freeMode ? enable : runFlag;
  assign syncRestart = active & companionSync & companionRestart; // R4

  // Top compare depends on the mode; capture modes never wrap on a compare.
  always_comb begin
    unique case (mode)
      MODE_PERIODIC, MODE_TIMEOUT, MODE_SINGLE: hitTop = (cnt == ccmp);
      MODE_EIGHT_BIT_WAVEFORM_MODE: hitTop = (cnt[7:0] == ccmp[7:0]);
      default: hitTop = 1'b0;
    endcase
  end

  // Edge actions that clear, capture or flag, per count mode.
  always_comb begin
    restartNow = 1'b0;
    capNow = 1'b0;
    flagSet = 1'b0;
    unique case (mode)
      MODE_SNAPSHOT: begin
        capNow = selEdge; // R16
        flagSet = selEdge; // R16
      end
      MODE_PERIOD: begin
        capNow = selEdge; // R17
        restartNow = selEdge; // R17
        flagSet = selEdge; // R17
      end
      MODE_WIDTH: begin
        restartNow = selEdge; // R18
        capNow = oppEdge; // R18
        flagSet = oppEdge; // R18
      end
      MODE_PERWIDTH: begin
        restartNow = (phase == PH_IDLE) & selEdge; // R19
        capNow = (phase == PH_WIDTH) & oppEdge; // R19
        flagSet = (phase == PH_PERIOD) & selEdge; // R19
      end
      default: begin
        // Periodic, timeout, single-shot and eight-bit modes flag at top only.
        flagSet = countTick & running & hitTop; // R14
      end
    endcase
  end

  // Divide-by-two toggle for the halved source.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      halfTick <= 1'b0;
    end else if (ce && active) begin
      halfTick <= ~halfTick; // R2
    end
  end

  // Control registers; unused bits are never stored.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctrlMain <= RST_CTRL; // R24
      ctrlMode <= RST_CTRL; // R24
      evtCtrl <= RST_CTRL; // R24
    end else if (wrEn) begin
      if (paddr == ADR_MAIN) begin
        ctrlMain <= pwdata[7:0] & MASK_MAIN; // R24
      end
      if (paddr == ADR_MODE) begin
        ctrlMode <= pwdata[7:0] & MASK_MODE; // R11
      end
      if (paddr == ADR_EVT) begin
        evtCtrl <= pwdata[7:0] & MASK_EVT; // R24
      end
    end
  end

  // Counter: a bus write has priority, then restarts, then counting.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cnt <= RST_WORD;
    end else if (ce) begin
      if (cntWrite) begin
        cnt <= pwdata[15:0];
      end else if (syncRestart || restartNow) begin
        cnt <= RST_WORD; // R4
      end else if (countTick && running) begin
        cnt <= hitTop ? RST_WORD : cnt + 16'h0001; // R1
      end
    end
  end

  // Capture register: a bus write, or a copy of the counter on capture.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ccmp <= RST_WORD;
    end else if (ce) begin
      if (ccmpWrite) begin
        ccmp <= pwdata[15:0];
      end else if (capNow) begin
        ccmp <= cnt; // R16
      end
    end
  end

  // Capture flag: a set in the same cycle as a clear wins.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      capFlag <= 1'b0;
    end else if (ce) begin
      if (flagSet) begin
        capFlag <= 1'b1;
      end else if (wrEn && paddr == ADR_FLAGS && pwdata[0]) begin
        capFlag <= 1'b0; // R23
      end else if (rdCcmp && mode >= MODE_SNAPSHOT && mode <= MODE_PERWIDTH) begin
        capFlag <= 1'b0; // R23
      end
    end
  end

  // Run state for the modes that start and stop on events or at top.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      runFlag <= 1'b0;
    end else if (ce) begin
      if (!enable) begin
        runFlag <= 1'b0; // R1
      end else if (mode == MODE_TIMEOUT) begin
        if (selEdge) begin
          runFlag <= 1'b1; // R15
        end else if (oppEdge) begin
          runFlag <= 1'b0; // R15
        end
      end else if (singleMode) begin
        if (!runFlag && startEdge) begin
          runFlag <= 1'b1; // R20
        end else if (countTick && runFlag && hitTop) begin
          runFlag <= 1'b0;
        end
      end else if (mode == MODE_PERWIDTH) begin
        if (restartNow) begin
          runFlag <= 1'b1; // R19
        end else if (flagSet) begin
          runFlag <= 1'b0; // R19
        end
      end
    end
  end

  // Period-and-width phase sequence.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      phase <= PH_IDLE;
    end else if (ce) begin
      if (!enable || mode != MODE_PERWIDTH) begin
        phase <= PH_IDLE;
      end else begin
        unique case (phase)
          PH_IDLE: if (selEdge) begin
            phase <= PH_WIDTH; // R19
          end
          PH_WIDTH: if (oppEdge) begin
            phase <= PH_PERIOD; // R19
          end
          PH_PERIOD: if (selEdge) begin
            phase <= PH_IDLE; // R19
          end
          default: phase <= PH_IDLE;
        endcase
      end
    end
  end

  // Waveform level: start level when idle outside single-shot and eight-bit, pulse in single-shot, duty in eight-bit.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      waveLevel <= 1'b0;
    end else if (ce) begin
      if (!enable) begin
        waveLevel <= (singleMode || mode == MODE_EIGHT_BIT_WAVEFORM_MODE) ? 1'b0 : startLevel; // R7 R8
      end else if (singleMode) begin
        if (!runFlag && startEdge) begin
          waveLevel <= 1'b1; // R5
        end else if (countTick && runFlag && hitTop) begin
          waveLevel <= 1'b0;
        end
      end else if (mode == MODE_EIGHT_BIT_WAVEFORM_MODE && countTick) begin
        if (hitTop) begin
          waveLevel <= 1'b1;
        end else if (cnt[7:0] == ccmp[15:8]) begin
          waveLevel <= 1'b0;
        end
      end
    end
  end

  // Pin drive; the async path follows the raw event without waiting a clock.
  logic asyncHigh;
  assign asyncHigh = singleMode & asyncOut & eventsOn & ~runFlag & eventIn; // R6
  assign waveformOut = pinEn & (waveLevel | asyncHigh); // R9
  assign waveformOe = pinEn; // R9 R10

  // Read data is loaded in the setup cycle so the access completes one cycle later.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      prdata <= '0;
      primed <= 1'b0;
    end else if (ce) begin
      primed <= psel & ~(penable & primed);
      if (psel && !penable) begin
        unique case (paddr)
          ADR_MAIN: prdata <= {24'h000000, ctrlMain}; // R24
          ADR_MODE: prdata <= {24'h000000, ctrlMode};
          ADR_EVT: prdata <= {24'h000000, evtCtrl};
          ADR_FLAGS: prdata <= {31'h00000000, capFlag};
          ADR_STATUS: prdata <= {31'h00000000, running};
          ADR_CNT: prdata <= {16'h0000, cnt};
          ADR_CCMP: prdata <= {16'h0000, ccmp};
          default: prdata <= '0;
        endcase
      end
    end
  end

  // Checks on the timer behaviour.
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_disabled_hold: assert property (ce && !enable && !cntWrite |=> $stable(cnt)) // R1
    else $error("counter moved while disabled");
  a_halved_rate: assert property (ce && countTick && clock_source_select == SRC_HALVED
    |=> !countTick || clock_source_select != SRC_HALVED) // R2
    else $error("halved source ticked twice in a row");
  a_standby_halt: assert property (ce && standbySleep && !standbyRun && clock_source_select != SRC_BORROWED
    && !cntWrite |=> $stable(cnt)) // R3
    else $error("counter moved in standby");
  a_sync_restart: assert property (ce && syncRestart && !cntWrite |=> cnt == 16'h0000) // R4
    else $error("companion restart did not clear counter");
  a_single_start: assert property (ce && singleMode && pinEn && !runFlag && startEdge
    |=> waveformOut && runFlag) // R5
    else $error("single-shot start did not raise output");
  a_async_direct: assert property (singleMode && asyncOut && pinEn && eventsOn && eventIn
    && !runFlag |-> waveformOut) // R6
    else $error("async event did not raise output");
  a_start_level: assert property (ce && !enable && !singleMode && mode != MODE_EIGHT_BIT_WAVEFORM_MODE
    |=> waveLevel == $past(startLevel)) // R7
    else $error("idle level differs from start level");
  a_start_ignored: assert property (ce && !enable && (singleMode || mode == MODE_EIGHT_BIT_WAVEFORM_MODE)
    |=> !waveLevel) // R8
    else $error("start level used in single-shot or eight-bit");
  a_pin_off: assert property (!pinEn |-> !waveformOut && !waveformOe) // R9
    else $error("pin driven while disabled");
  a_events_ignored: assert property (!eventsOn |-> !capNow && !restartNow) // R13
    else $error("event acted while not accepted");
  a_capture_copy: assert property (ce && capNow && !ccmpWrite |=> ccmp == $past(cnt)) // R16
    else $error("capture did not copy counter");
  a_period_restart: assert property (ce && mode == MODE_PERIOD && selEdge && !cntWrite
    |=> cnt == 16'h0000 && capFlag) // R17
    else $error("period edge did not restart and flag");
  a_flag_wins: assert property (ce && flagSet |=> capFlag) // R23
    else $error("flag set was lost");
  a_ctrl_zero: assert property (ce && psel && !penable && paddr == ADR_MAIN
    |=> (prdata[7:0] & ~MASK_MAIN) == 8'h00) // R24
    else $error("unused control bits read nonzero");

  c_single_shot: cover property (singleMode && startEdge ##1 runFlag);
  c_perwidth_done: cover property (mode == MODE_PERWIDTH && phase == PH_PERIOD && selEdge);
  c_width_capture: cover property (mode == MODE_WIDTH && capNow);
  c_async_out: cover property (asyncHigh && pinEn);
endmodule : ctb_capture_timer

// ### rtl/ctb_pkg.sv
// Constants and types shared by the capture timer control block.
// Assumes a 32-bit APB slave port and one 100 MHz core clock.
package ctb_pkg;
  // Register indices; the byte address on the bus is four times the index.
  localparam logic [7:0] IDX_MAIN = 8'h00;
  localparam logic [7:0] IDX_MODE = 8'h01;
  localparam logic [7:0] IDX_EVT = 8'h04;
  localparam logic [7:0] IDX_FLAGS = 8'h06;
  localparam logic [7:0] IDX_STATUS = 8'h07;
  localparam logic [7:0] IDX_CNT = 8'h0a;
  localparam logic [7:0] IDX_CCMP = 8'h0c;
  localparam logic [7:0] ADR_MAIN = {IDX_MAIN[5:0], 2'b00};
  localparam logic [7:0] ADR_MODE = {IDX_MODE[5:0], 2'b00};
  localparam logic [7:0] ADR_EVT = {IDX_EVT[5:0], 2'b00};
  localparam logic [7:0] ADR_FLAGS = {IDX_FLAGS[5:0], 2'b00};
  localparam logic [7:0] ADR_STATUS = {IDX_STATUS[5:0], 2'b00};
  localparam logic [7:0] ADR_CNT = {IDX_CNT[5:0], 2'b00};
  localparam logic [7:0] ADR_CCMP = {IDX_CCMP[5:0], 2'b00};
  // Reset values.
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  // Writable bit masks of the three control registers.
  localparam logic [7:0] MASK_MAIN = 8'h57;
  localparam logic [7:0] MASK_MODE = 8'h77;
  localparam logic [7:0] MASK_EVT = 8'h51;
  // Field positions in the first control register.
  localparam int BIT_ENABLE = 0;
  localparam int LSB_CLOCK_SOURCE_SELECT = 1;
  localparam int BIT_SYNC = 4;
  localparam int BIT_STDBY = 6;
  // Field positions in the second control register.
  localparam int LSB_MODE = 0;
  localparam int BIT_PINEN = 4;
  localparam int BIT_INIT = 5;
  localparam int BIT_ASYNC = 6;
  // Field positions in the event control register.
  localparam int BIT_ACCEPT = 0;
  localparam int BIT_EDGE = 4;
  localparam int BIT_FILTER = 6;
  // Number of equal samples before the filtered event is taken as stable.
  localparam int FILTER_DEPTH = 4;
  // Clock source codes.
  localparam logic [1:0] SRC_UNDIV = 2'h0;
  localparam logic [1:0] SRC_HALVED = 2'h1;
  localparam logic [1:0] SRC_BORROWED = 2'h3;
  // Count mode codes.
  localparam logic [2:0] MODE_PERIODIC = 3'h0;
  localparam logic [2:0] MODE_TIMEOUT = 3'h1;
  localparam logic [2:0] MODE_SNAPSHOT = 3'h2;
  localparam logic [2:0] MODE_PERIOD = 3'h3;
  localparam logic [2:0] MODE_WIDTH = 3'h4;
  localparam logic [2:0] MODE_PERWIDTH = 3'h5;
  localparam logic [2:0] MODE_SINGLE = 3'h6;
  localparam logic [2:0] MODE_EIGHT_BIT_WAVEFORM_MODE = 3'h7;
  // Phases of the period-and-width measurement.
  typedef enum logic [2:0] {
    PH_IDLE = 3'b001,
    PH_WIDTH = 3'b010,
    PH_PERIOD = 3'b100
  } ctb_phase_t;
endpackage : ctb_pkg

// ### rtl/ctb_evt_if.sv
// Interface carrying the conditioned event from the filter to the timer.
// Assumes both ends run on the same core clock.
interface ctb_evt_if;
  logic level; // Conditioned event level.
  logic rise; // One-cycle pulse on a rising edge of level.
  logic fall; // One-cycle pulse on a falling edge of level.
  modport src (output level, output rise, output fall);
  modport dst (input level, input rise, input fall);
endinterface : ctb_evt_if

// ### rtl/ctb_event_filter.sv
// Event input conditioner: optional four-sample noise filter and edge detector.
// Assumes the event input is synchronous to core_clk.
module ctb_event_filter
  import ctb_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic eventIn,
  input wire logic filterOn,
  ctb_evt_if.src evt
);
  logic [FILTER_DEPTH-1:0] samples; // Last observed event samples.
  logic level; // Conditioned level.
  logic prevLevel; // Level one cycle earlier, for edge detection.

  // Shift in a new sample each enabled cycle.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      samples <= '0;
    end else if (ce) begin
      samples <= {samples[FILTER_DEPTH-2:0], eventIn};
    end
  end

  // The level follows the input directly, or only once all samples agree.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      level <= 1'b0;
    end else if (ce) begin
      if (!filterOn) begin
        level <= eventIn;
      end else if (&samples) begin
        level <= 1'b1; // R21
      end else if (~|samples) begin
        level <= 1'b0; // R21
      end
    end
  end

  // Remember the previous level.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      prevLevel <= 1'b0;
    end else if (ce) begin
      prevLevel <= level;
    end
  end

  assign evt.level = level;
  assign evt.rise = level & ~prevLevel;
  assign evt.fall = ~level & prevLevel;

  // A mixed sample window never changes the filtered level.
  a_filter_hold: assert property (@(posedge core_clk) disable iff (rst)
    ce && filterOn && !(&samples) && (|samples) |=> $stable(level)) // R21
    else $error("filtered level changed on unstable samples");
endmodule : ctb_event_filter

// ### verification/ctb_far_side.sv
// Model of the event channel, the companion timer and the waveform pin.
// Assumes one core clock shared with the timer and a pin with a pull-down.
module ctb_far_side
  import ctb_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic evtReq,
  input wire logic waveformOut,
  input wire logic waveformOe,
  output logic eventIn,
  output logic companionTick,
  output logic companionRestart,
  output logic pinLevel
);
  logic [3:0] tickDiv; // Companion prescaler and period counter.

  // The event level is registered, so any request lasts whole cycles.
  always_ff @(posedge core_clk) begin
    eventIn <= rst ? 1'b0 : evtReq;
  end

  // The companion ticks every fourth cycle and restarts every sixteenth.
  always_ff @(posedge core_clk) begin
    tickDiv <= rst ? 4'h0 : tickDiv + 4'h1;
  end
  assign companionTick = (tickDiv[1:0] == 2'h3);
  assign companionRestart = (tickDiv == 4'hf);

  // The port drives the pin as an output; undriven it falls to the pull-down.
  assign pinLevel = waveformOe ? waveformOut : 1'b0;
endmodule : ctb_far_side

// ### verification/ctb_capture_timer_tb_top.sv
// Self-checking bench for the capture timer control block.
// Assumes the APB slave answers within a few cycles and ce is held high.
`define CHK(nm, ex, got) begin nCompared++; if ((got) !== (ex)) begin \
  $display("ERROR %s expected %h seen %h", nm, ex, got); fails++; end end
module ctb_capture_timer_tb_top
  import ctb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, rst, psel, penable, pwrite, pready, pslverr; // Bus and clock.
  logic [7:0] paddr; // Byte address.
  logic [31:0] pwdata, prdata; // Bus data.
  logic eventIn, companionTick, companionRestart, waveformOut, waveformOe;
  logic evtReq, pinLevel; // Event request to the model and the pin seen.
  logic sleep; // Standby sleep request to the timer.
  int fails, nCompared; // Mismatch and comparison counts.
  // Expected flag and run bits per stage, one bit per count mode.
  localparam logic [7:0] FLG [3] = '{8'h0c, 8'h1c, 8'h3c};
  localparam logic [7:0] RUN [3] = '{8'hff, 8'hfd, 8'hdf};

  ctb_capture_timer i_ctb_capture_timer (.core_clk(core_clk), .rst(rst), .ce(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .eventIn(eventIn), .companionTick(companionTick),
    .companionRestart(companionRestart), .standbySleep(sleep), .waveformOut(waveformOut),
    .waveformOe(waveformOe));
  ctb_far_side i_ctb_far_side (.core_clk(core_clk), .rst(rst), .evtReq(evtReq),
    .waveformOut(waveformOut), .waveformOe(waveformOe), .eventIn(eventIn),
    .companionTick(companionTick), .companionRestart(companionRestart), .pinLevel(pinLevel));

  // The clock runs at 100 MHz.
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Prints the counts and the verdict, then stops the run.
  task automatic endOfTest();
    $display("compared %0d mismatches %0d", nCompared, fails);
    if (fails == 0 && nCompared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : endOfTest

  // One APB transfer; pready, read data and error are taken at the completing rising edge.
  // One idle cycle follows, so the next setup never reassigns psel in the same time step.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) begin
      n++;
      if (n > 20) begin
        fails++;
        endOfTest();
      end
      @(posedge core_clk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask : apb

  // Register write.
  task automatic wrk(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask : wrk

  // Register read with a comparison.
  task automatic rdk(input logic [7:0] a, input logic [31:0] ex);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    `CHK($sformatf("reg %h", a), ex, q)
  endtask : rdk

  // Main sequence.
  initial begin
    logic [31:0] q;
    logic e;
    logic [31:0] q2;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    evtReq = 1'b0;
    sleep = 1'b0;
    fails = 0;
    nCompared = 0;
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    rdk(ADR_MAIN, 32'h0);
    rdk(ADR_MODE, 32'h0);
    rdk(ADR_EVT, 32'h0);
    wrk(ADR_MAIN, 32'hffff_fffe);
    rdk(ADR_MAIN, 32'h56);
    wrk(ADR_MODE, 32'hffff_ffff);
    rdk(ADR_MODE, 32'h77);
    `CHK("pin enable", 1'b1, waveformOe)
    wrk(ADR_EVT, 32'hffff_ffff);
    rdk(ADR_EVT, 32'h51);
    apb(1'b0, 8'h08, 32'h0, q, e);
    `CHK("unmapped error", 1'b1, e)
    wrk(ADR_MODE, 32'h0);
    `CHK("pin released", 1'b0, pinLevel)
    // Clock source codes 0, 1 and 3 read back as written.
    for (int s = 0; s < 4; s++) begin
      if (s != 2) begin
        wrk(ADR_MAIN, 32'(s) << 1);
        rdk(ADR_MAIN, 32'(s) << 1);
      end
    end
    // Each mode sees selected, opposite, then selected event edges.
    // The second pass selects falling edges with the noise filter on.
    for (int k = 0; k < 2; k++) begin
      for (int m = 0; m < 8; m++) begin
        wrk(ADR_FLAGS, 32'h1);
        wrk(ADR_EVT, 32'h0);
        evtReq <= (k == 1);
        repeat (8) @(posedge core_clk);
        rdk(ADR_FLAGS, 32'h0);
        wrk(ADR_MAIN, 32'h0);
        wrk(ADR_MODE, 32'(m));
        wrk(ADR_CNT, 32'h0);
        wrk(ADR_CCMP, 32'hffff);
        wrk(ADR_EVT, (k == 1) ? 32'h51 : 32'h1);
        wrk(ADR_MAIN, 32'h1);
        for (int s = 0; s < 3; s++) begin
          evtReq <= ((s != 1) != (k == 1));
          repeat (8) @(posedge core_clk);
          rdk(ADR_FLAGS, {31'h0, FLG[s][m]});
          rdk(ADR_STATUS, {31'h0, RUN[s][m]});
        end
        if (m == 2) begin
          apb(1'b0, ADR_CCMP, 32'h0, q, e);
          rdk(ADR_FLAGS, 32'h0);
        end
      end
    end
    // The start level drives the idle pin in periodic mode, but not in single-shot mode.
    wrk(ADR_MAIN, 32'h0);
    wrk(ADR_MODE, 32'h30);
    repeat (2) @(posedge core_clk);
    `CHK("start level", 1'b1, pinLevel)
    wrk(ADR_MODE, 32'h36);
    repeat (2) @(posedge core_clk);
    `CHK("start ignored", 1'b0, pinLevel)
    // Synchronised single shot: the pin rises only once the counter runs, and falls at top.
    wrk(ADR_MODE, 32'h16);
    wrk(ADR_EVT, 32'h1);
    wrk(ADR_CNT, 32'h0);
    wrk(ADR_CCMP, 32'h10);
    wrk(ADR_MAIN, 32'h1);
    evtReq <= 1'b1;
    repeat (2) @(negedge core_clk);
    `CHK("sync delay", 1'b0, pinLevel)
    @(posedge core_clk);
    repeat (8) @(posedge core_clk);
    `CHK("sync pulse", 1'b1, pinLevel)
    repeat (30) @(posedge core_clk);
    `CHK("pulse end", 1'b0, pinLevel)
    // Direct single shot: the pin follows the event before any clock edge acts on it.
    evtReq <= 1'b0;
    wrk(ADR_MAIN, 32'h0);
    wrk(ADR_MODE, 32'h56);
    wrk(ADR_MAIN, 32'h1);
    evtReq <= 1'b1;
    repeat (2) @(negedge core_clk);
    `CHK("async out", 1'b1, pinLevel)
    @(posedge core_clk);
    // The borrowed source counts at the companion rate, well below the core rate.
    wrk(ADR_MAIN, 32'h0);
    wrk(ADR_MODE, 32'h0);
    wrk(ADR_CNT, 32'h0);
    wrk(ADR_CCMP, 32'hffff);
    wrk(ADR_MAIN, 32'h7);
    repeat (40) @(posedge core_clk);
    apb(1'b0, ADR_CNT, 32'h0, q, e);
    `CHK("borrowed rate", 1'b1, q < 32'h10)
    // Companion restarts every sixteen cycles keep the counter below sixteen.
    wrk(ADR_MAIN, 32'h11);
    repeat (40) @(posedge core_clk);
    apb(1'b0, ADR_CNT, 32'h0, q, e);
    `CHK("sync restart", 1'b1, q < 32'h10)
    // Standby halts the counter unless standby run is set.
    wrk(ADR_MAIN, 32'h1);
    sleep <= 1'b1;
    apb(1'b0, ADR_CNT, 32'h0, q, e);
    repeat (10) @(posedge core_clk);
    apb(1'b0, ADR_CNT, 32'h0, q2, e);
    `CHK("standby halt", q, q2)
    wrk(ADR_MAIN, 32'h41);
    apb(1'b0, ADR_CNT, 32'h0, q, e);
    repeat (10) @(posedge core_clk);
    apb(1'b0, ADR_CNT, 32'h0, q2, e);
    `CHK("standby run", 1'b1, q2 != q)
    sleep <= 1'b0;
    endOfTest();
  end
endmodule : ctb_capture_timer_tb_top
